/* File: hdl/acs_pkg.sv */
// Constants and types shared by the converter sequencer control block
package acs_pkg;
  localparam int NSEQ = 4;
  // Register byte offsets
  localparam logic [11:0] OFF_ACTSS = 12'h000;
  localparam logic [11:0] OFF_RIS   = 12'h004;
  localparam logic [11:0] OFF_IM    = 12'h008;
  localparam logic [11:0] OFF_ISC   = 12'h00C;
  localparam logic [11:0] OFF_OSTAT = 12'h010;
  localparam logic [11:0] OFF_EMUX  = 12'h014;
  localparam logic [11:0] OFF_USTAT = 12'h018;
  localparam logic [11:0] OFF_PRI   = 12'h020;
  localparam logic [11:0] OFF_PSSI  = 12'h028;
  localparam logic [11:0] OFF_SAC   = 12'h030;
  localparam logic [11:0] OFF_TMLB  = 12'h100;
  // Per-sequencer block: base + index * stride, then sub-offset
  localparam logic [11:0] SS_BASE   = 12'h040;
  localparam logic [11:0] SS_STRIDE = 12'h020;
  localparam logic [4:0]  SUB_MUX   = 5'h00;
  localparam logic [4:0]  SUB_CTL   = 5'h04;
  localparam logic [4:0]  SUB_FIFO  = 5'h08;
  localparam logic [4:0]  SUB_FSTAT = 5'h0C;
  // Reset values and masks
  localparam logic [15:0] PRI_RST   = 16'h3210;
  localparam logic [15:0] PRI_MASK  = 16'h3333;
  localparam logic [31:0] CTL3_RST  = 32'h0000_0002;
  localparam logic [2:0]  SAC_MAX   = 3'h6;
  // Step control nibble fields
  localparam int CTL_DIFF = 0;
  localparam int CTL_END  = 1;
  localparam int CTL_IE   = 2;
  localparam int CTL_TEMP = 3;
  // Status word fields
  localparam int FST_EMPTY = 8;
  localparam int FST_FULL  = 12;
  // Trigger select codes
  localparam logic [3:0] TRG_SOFT   = 4'h0;
  localparam logic [3:0] TRG_ALWAYS = 4'hF;
  // Converter clock rate, derived by a fractional accumulator
  localparam int SYS_FREQ_KHZ  = 40000;
  localparam int CONV_FREQ_KHZ = 16667;
  localparam logic [16:0] PH_STEP = 17'(CONV_FREQ_KHZ);
  localparam logic [16:0] PH_MOD  = 17'(SYS_FREQ_KHZ);

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_CONV  = 2'b01,
    ST_WAIT  = 2'b11,
    ST_STORE = 2'b10
  } acs_state_t;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } acs_bus_t;

  typedef struct packed {
    logic       start;
    logic [3:0] chan;
    logic       diff;
    logic       temp;
  } acs_conv_t;
endpackage

/* File: hdl/acs_top.sv */
// Sequencer, FIFO, trigger and interrupt control of a 10-bit converter
`timescale 1ns/1ps
// What this block does
// - Four sequencers: 8, 4, 4 and 1 steps with equally deep FIFOs.
// - FIFO words are 32 bits, result in the low 10 bits.
// - Each step has a 4-bit input nibble and a 4-bit control nibble.
// - Inputs may repeat; any step may raise a raw interrupt.
// - The step flagged end-of-sequence is the last one converted.
// - Reading the FIFO address returns and removes the oldest entry.
// - Status word shows head, tail, full and empty of each FIFO.
// - Overflow and underflow are recorded in sticky bits.
// - Conversions run at a converter rate near 16.667 MHz.
// - Raw interrupt reaches the output only when its mask bit is set.
// - Masked view shows raw and enabled; writing 1 clears it.
// - Concurrent triggers served by 2-bit priority, 0 first.
// - Each sequencer picks its trigger: software, always or peripheral.
// - Writing 1 to an initiate bit starts a software-triggered sequencer whose ACTSS bit is set.
// - Up to 64 conversions are averaged into one FIFO entry.
// - Averaging off after reset; one setting for all steps.
// - Single-ended results run 0x000 to 0x3FF.
// - Differential step selects pair k: inputs 2k and 2k+1.
// - Differential results are offset-coded around 0x1FF.
// - Loopback test mode runs sequences without the analog core.
// - Priority register resets to 0x3210.
module acs_top (
  input  wire logic             CLOCK,
  input  wire logic             RESETN,
  input  wire acs_pkg::acs_bus_t BUS,
  output logic [31:0]           BUS_RDATA,
  output acs_pkg::acs_conv_t    CONV_REQ,
  output logic                  CONV_TICK,
  input  wire logic             CONV_DONE,
  input  wire logic [9:0]       CONV_RESULT,
  input  wire logic [3:0]       TRIG_IN,
  output logic [3:0]            SEQ_IRQ
);
  typedef struct packed {
    acs_pkg::acs_state_t st;
    logic [1:0]          cur;
    logic [2:0]          step;
    logic [3:0]          pend;
    logic [3:0]          actss;
    logic [3:0]          ris;
    logic [3:0]          im;
    logic [3:0]          ostat;
    logic [3:0]          ustat;
    logic [15:0]         emux;
    logic [15:0]         pri;
    logic [2:0]          sac;
    logic                tmlb;
    logic [3:0][31:0]    mux;
    logic [3:0][31:0]    ctl;
    logic [3:0][7:0][9:0] mem;
    logic [3:0][2:0]     wp;
    logic [3:0][2:0]     rp;
    logic [3:0][3:0]     cnt;
    logic [15:0]         acc;
    logic [6:0]          nacc;
    logic [9:0]          lb;
    logic [15:0]         ph;
    logic                tick;
    logic [31:0]         rdata;
    logic [3:0]          irq;
    acs_pkg::acs_conv_t  conv;
  } acs_regs_t;

  acs_regs_t   r_q;
  acs_regs_t   r_d;
  logic [3:0]  push;
  logic [3:0]  pop;
  logic [3:0]  trig;
  logic [9:0]  avg;
  logic [16:0] ph_sum;
  logic [2:0]  win;
  logic [3:0]  nib_ctl;
  logic [3:0]  nib_mux;
  logic        ss_hit;
  logic [1:0]  ss_idx;
  logic [4:0]  ss_sub;
  logic [11:0] ss_off;

  function automatic logic [3:0] depth(input logic [1:0] s);
    case (s)
      2'd0:    return 4'h8;
      2'd3:    return 4'h1;
      default: return 4'h4;
    endcase
  endfunction

  function automatic logic [2:0] nxt(input logic [2:0] p,
                                     input logic [1:0] s);
    logic [3:0] d;
    d = depth(s);
    if ({1'b0, p} == d - 4'h1)
      return 3'h0;
    return p + 3'h1;
  endfunction

  // Lowest priority value wins; result bit 2 says something is pending
  function automatic logic [2:0] pick(input logic [3:0]  p,
                                      input logic [15:0] pr);
    logic [2:0] best;
    logic [1:0] bp;
    best = 3'h0;
    bp   = 2'h3;
    for (int i = 0; i < acs_pkg::NSEQ; i++)
    begin
      if (p[i] && (!best[2] || pr[4*i +: 2] < bp))
      begin
        best = {1'b1, 2'(i)};
        bp   = pr[4*i +: 2];
      end
    end
    return best;
  endfunction

  assign ss_off = BUS.addr - acs_pkg::SS_BASE;
  assign ss_idx = ss_off[6:5];
  assign ss_sub = ss_off[4:0];
  assign ss_hit = BUS.addr >= acs_pkg::SS_BASE &&
                  BUS.addr < acs_pkg::SS_BASE + 12'h080;
  assign nib_ctl = r_q.ctl[r_q.cur][4*r_q.step +: 4];
  assign nib_mux = r_q.mux[r_q.cur][4*r_q.step +: 4];
  assign avg     = 10'(r_q.acc >> r_q.sac);

  always_comb
  begin
    r_d        = r_q;
    push       = '0;
    pop        = '0;
    r_d.rdata  = '0;
    r_d.conv.start = 1'b0;
    // Fractional divider paces conversion starts
    ph_sum = {1'b0, r_q.ph} + acs_pkg::PH_STEP;
    if (ph_sum >= acs_pkg::PH_MOD)
    begin
      r_d.ph   = 16'(ph_sum - acs_pkg::PH_MOD);
      r_d.tick = 1'b1;
    end
    else
    begin
      r_d.ph   = ph_sum[15:0];
      r_d.tick = 1'b0;
    end

    // Register writes
    if (BUS.wr)
    begin
      case (BUS.addr)
        acs_pkg::OFF_ACTSS: r_d.actss = BUS.wdata[3:0];
        acs_pkg::OFF_IM:    r_d.im    = BUS.wdata[3:0];
        acs_pkg::OFF_ISC:   r_d.ris   = r_q.ris & ~BUS.wdata[3:0];
        acs_pkg::OFF_OSTAT: r_d.ostat = r_q.ostat & ~BUS.wdata[3:0];
        acs_pkg::OFF_USTAT: r_d.ustat = r_q.ustat & ~BUS.wdata[3:0];
        acs_pkg::OFF_EMUX:  r_d.emux  = BUS.wdata[15:0];
        acs_pkg::OFF_PRI:   r_d.pri   = BUS.wdata[15:0] & acs_pkg::PRI_MASK;
        acs_pkg::OFF_SAC:
          r_d.sac = (BUS.wdata[2:0] > acs_pkg::SAC_MAX) ?
                    acs_pkg::SAC_MAX : BUS.wdata[2:0];
        acs_pkg::OFF_TMLB:  r_d.tmlb  = BUS.wdata[0];
        default:
        begin
          if (ss_hit && ss_sub == acs_pkg::SUB_MUX)
            r_d.mux[ss_idx] = BUS.wdata;
          else if (ss_hit && ss_sub == acs_pkg::SUB_CTL)
            r_d.ctl[ss_idx] = BUS.wdata;
        end
      endcase
    end

    // Register reads, data returned in the following cycle
    if (BUS.rd)
    begin
      case (BUS.addr)
        acs_pkg::OFF_ACTSS: r_d.rdata = {28'h0, r_q.actss};
        acs_pkg::OFF_RIS:   r_d.rdata = {28'h0, r_q.ris};
        acs_pkg::OFF_IM:    r_d.rdata = {28'h0, r_q.im};
        acs_pkg::OFF_ISC:   r_d.rdata = {28'h0, r_q.ris & r_q.im};
        acs_pkg::OFF_OSTAT: r_d.rdata = {28'h0, r_q.ostat};
        acs_pkg::OFF_USTAT: r_d.rdata = {28'h0, r_q.ustat};
        acs_pkg::OFF_EMUX:  r_d.rdata = {16'h0, r_q.emux};
        acs_pkg::OFF_PRI:   r_d.rdata = {16'h0, r_q.pri};
        acs_pkg::OFF_SAC:   r_d.rdata = {29'h0, r_q.sac};
        acs_pkg::OFF_TMLB:  r_d.rdata = {31'h0, r_q.tmlb};
        default:
        begin
          if (ss_hit)
          begin
            case (ss_sub)
              acs_pkg::SUB_MUX: r_d.rdata = r_q.mux[ss_idx];
              acs_pkg::SUB_CTL: r_d.rdata = r_q.ctl[ss_idx];
              acs_pkg::SUB_FIFO:
              begin
                pop[ss_idx] = 1'b1;
                if (r_q.cnt[ss_idx] != 4'h0)
                  r_d.rdata = {22'h0,
                    r_q.mem[ss_idx][r_q.rp[ss_idx]]};
              end
              acs_pkg::SUB_FSTAT:
              begin
                r_d.rdata[2:0]  = r_q.rp[ss_idx];
                r_d.rdata[6:4]  = r_q.wp[ss_idx];
                r_d.rdata[acs_pkg::FST_EMPTY] = r_q.cnt[ss_idx] == 4'h0;
                r_d.rdata[acs_pkg::FST_FULL]  =
                  r_q.cnt[ss_idx] == depth(ss_idx);
              end
              default: r_d.rdata = '0;
            endcase
          end
        end
      endcase
    end

    // Trigger selection per sequencer
    for (int s = 0; s < acs_pkg::NSEQ; s++)
    begin
      case (r_q.emux[4*s +: 4])
        acs_pkg::TRG_SOFT:
          trig[s] = BUS.wr && BUS.addr == acs_pkg::OFF_PSSI &&
                    BUS.wdata[s];
        acs_pkg::TRG_ALWAYS: trig[s] = 1'b1;
        4'h1:    trig[s] = TRIG_IN[0];
        4'h2:    trig[s] = TRIG_IN[1];
        4'h3:    trig[s] = TRIG_IN[2];
        4'h4:    trig[s] = TRIG_IN[3];
        default: trig[s] = 1'b0;
      endcase
      if (trig[s] && r_q.actss[s])
        r_d.pend[s] = 1'b1;
    end

    win = pick(r_q.pend, r_q.pri);
    case (r_q.st)
      acs_pkg::ST_IDLE:
      begin
        if (win[2])
        begin
          r_d.cur  = win[1:0];
          r_d.step = 3'h0;
          r_d.acc  = '0;
          r_d.nacc = '0;
          r_d.pend[win[1:0]] = 1'b0;
          r_d.st   = acs_pkg::ST_CONV;
        end
      end
      acs_pkg::ST_CONV:
      begin
        if (r_q.tick)
        begin
          r_d.conv.start = !r_q.tmlb;
          // Pair k drives inputs 2k and 2k+1 in the core
          r_d.conv.chan  = nib_ctl[acs_pkg::CTL_DIFF] ?
                           {2'h0, nib_mux[1:0]} : nib_mux;
          r_d.conv.diff  = nib_ctl[acs_pkg::CTL_DIFF];
          r_d.conv.temp  = nib_ctl[acs_pkg::CTL_TEMP];
          r_d.st         = acs_pkg::ST_WAIT;
        end
      end
      acs_pkg::ST_WAIT:
      begin
        // Core codes are passed on untouched: 0x000-0x3FF straight,
        // differential offset around 0x1FF
        if (r_q.tmlb || CONV_DONE)
        begin
          r_d.acc  = r_q.acc + (r_q.tmlb ? {6'h0, r_q.lb} :
                                           {6'h0, CONV_RESULT});
          r_d.lb   = r_q.lb + 10'h1;
          r_d.nacc = r_q.nacc + 7'h1;
          r_d.st   = acs_pkg::ST_STORE;
        end
      end
      acs_pkg::ST_STORE:
      begin
        if (r_q.nacc != (7'h1 << r_q.sac))
          r_d.st = acs_pkg::ST_CONV;
        else
        begin
          push[r_q.cur] = 1'b1;
          r_d.acc  = '0;
          r_d.nacc = '0;
          if (nib_ctl[acs_pkg::CTL_IE])
            r_d.ris[r_q.cur] = 1'b1;
          if (nib_ctl[acs_pkg::CTL_END] ||
              {1'b0, r_q.step} == depth(r_q.cur) - 4'h1)
            r_d.st = acs_pkg::ST_IDLE;
          else
          begin
            r_d.step = r_q.step + 3'h1;
            r_d.st   = acs_pkg::ST_CONV;
          end
        end
      end
      default: r_d.st = acs_pkg::ST_IDLE;
    endcase

    // FIFO pointer and count upkeep; sticky flags set after clears
    for (int s = 0; s < acs_pkg::NSEQ; s++)
    begin
      if (push[s] && r_q.cnt[s] == depth(2'(s)))
        r_d.ostat[s] = 1'b1;
      else if (push[s])
      begin
        r_d.mem[s][r_q.wp[s]] = avg;
        r_d.wp[s] = nxt(r_q.wp[s], 2'(s));
      end
      if (pop[s] && r_q.cnt[s] == 4'h0)
        r_d.ustat[s] = 1'b1;
      else if (pop[s])
        r_d.rp[s] = nxt(r_q.rp[s], 2'(s));
      r_d.cnt[s] = r_q.cnt[s]
        + {3'h0, push[s] && r_q.cnt[s] != depth(2'(s))}
        - {3'h0, pop[s] && r_q.cnt[s] != 4'h0};
    end
    r_d.irq = r_d.ris & r_d.im;
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RESETN)
    begin
      r_q        <= '0;
      r_q.st     <= acs_pkg::ST_IDLE;
      r_q.pri    <= acs_pkg::PRI_RST;
      r_q.ctl[3] <= acs_pkg::CTL3_RST;
    end
    else
      r_q <= r_d;
  end

  assign BUS_RDATA = r_q.rdata;
  assign CONV_REQ  = r_q.conv;
  assign CONV_TICK = r_q.tick;
  assign SEQ_IRQ   = r_q.irq;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESETN);

  sequence s_conv_go;
    r_q.st == acs_pkg::ST_CONV && r_q.tick && !r_q.tmlb;
  endsequence
  sequence s_conv_issued;
    r_q.conv.start && r_q.st == acs_pkg::ST_WAIT;
  endsequence

  a_conv_start_issue: assert property (s_conv_go |=> s_conv_issued)
    else $error("conversion start not issued");
  a_trig_inactive_ign: assert property (
    ((r_q.pend & ~$past(r_q.pend)) & ~$past(r_q.actss)) == 4'h0)
    else $error("trigger latched for inactive sequencer");
  a_fifo_depth_bound: assert property (
    r_q.cnt[0] <= 4'h8 && r_q.cnt[1] <= 4'h4 &&
    r_q.cnt[2] <= 4'h4 && r_q.cnt[3] <= 4'h1)
    else $error("fifo count past depth");
  // Output follows raw and mask with no extra cycle of delay
  a_irq_mask_gate: assert property (
    SEQ_IRQ == (r_q.ris & r_q.im))
    else $error("interrupt raised without raw and mask");
  a_ovf_flag_sticky: assert property (
    !$past(BUS.wr && BUS.addr == acs_pkg::OFF_OSTAT) |->
    (r_q.ostat & $past(r_q.ostat)) == $past(r_q.ostat))
    else $error("overflow flag lost");
  a_uflow_on_empty: assert property (
    BUS.rd && BUS.addr == acs_pkg::SS_BASE + 12'(acs_pkg::SUB_FIFO) &&
    r_q.cnt[0] == 4'h0
    |=> r_q.ustat[0] && BUS_RDATA == 32'h0)
    else $error("underflow not recorded");
  a_pri_after_reset: assert property (
    $past(!RESETN) |-> r_q.pri == acs_pkg::PRI_RST)
    else $error("priority reset value wrong");
  a_avg_off_direct: assert property (
    r_q.sac == 3'h0 && r_q.st == acs_pkg::ST_WAIT && CONV_DONE
    && !r_q.tmlb |=> r_q.st == acs_pkg::ST_STORE ##1
    r_q.st != acs_pkg::ST_STORE)
    else $error("averaging not bypassed");
  a_end_step_idle: assert property (
    r_q.st == acs_pkg::ST_STORE && r_q.nacc == (7'h1 << r_q.sac) &&
    nib_ctl[acs_pkg::CTL_END] |=> r_q.st == acs_pkg::ST_IDLE)
    else $error("sequence ran past end step");
endmodule

/* File: testbench/acs_core_model.sv */
// Behavioural converter core that answers start pulses after a delay
`timescale 1ns/1ps
module acs_core_model (
  input  wire logic               CLOCK,
  input  wire acs_pkg::acs_conv_t REQ,
  input  wire logic [3:0]         DELAY,
  output logic                    DONE,
  output logic [9:0]              RESULT
);
  logic [9:0] code;
  initial
  begin
    DONE = 1'b0;
    RESULT = 10'h000;
    forever
    begin
      @(posedge CLOCK);
      if (REQ.start === 1'b1)
      begin
        // Code echoes the mode and input that were asked for
        code = {REQ.diff, REQ.temp, REQ.chan, 4'h5};
        repeat (DELAY) @(posedge CLOCK);
        DONE <= 1'b1;
        RESULT <= code;
        @(posedge CLOCK);
        DONE <= 1'b0;
        // Stale data lines never keep the last code
        RESULT <= ~code;
      end
    end
  end
endmodule

/* File: testbench/adc_sequencer_control_test.sv */
// Self-checking bench for the converter sequencer control block
`timescale 1ns/1ps
module adc_sequencer_control_test;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  // Converter ticks expected in a window of 1200 system clocks
  localparam int TWIN = 1200 * acs_pkg::CONV_FREQ_KHZ /
                        acs_pkg::SYS_FREQ_KHZ;
  acs_pkg::acs_bus_t  bus;
  acs_pkg::acs_conv_t req;
  logic        clock;
  logic        resetn;
  logic [31:0] rdata;
  logic        done;
  logic [9:0]  result;
  logic [3:0]  trig;
  logic [3:0]  irq;
  logic [3:0]  delay = 4'h0;
  logic        tick;
  logic [31:0] rnd;
  logic [31:0] mux;
  logic [63:0] ent;
  logic        rd_seen;
  logic [63:0] exp_q[$];
  logic [3:0]  chan_q[$];
  int          num_errors;
  int          checks_done;
  int          n_starts;
  int          n_ticks;
  int          t0;
  int          s0;
  int          cyc;
  int          i;

  acs_top i_dut (
    .CLOCK       (clock),
    .RESETN      (resetn),
    .BUS         (bus),
    .BUS_RDATA   (rdata),
    .CONV_REQ    (req),
    .CONV_TICK   (tick),
    .CONV_DONE   (done),
    .CONV_RESULT (result),
    .TRIG_IN     (trig),
    .SEQ_IRQ     (irq)
  );

  acs_core_model i_core (
    .CLOCK  (clock),
    .REQ    (req),
    .DELAY  (delay),
    .DONE   (done),
    .RESULT (result)
  );

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    xs = v ^ (v << 5);
  endfunction

  function automatic logic [11:0] ssa(input int n, input logic [4:0] s);
    ssa = acs_pkg::SS_BASE + 12'(n) * acs_pkg::SS_STRIDE + 12'(s);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("errors=%0d checks=%0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    @(posedge clock);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    exp_q.push_back({m, e});
    @(posedge clock);
    bus.rd <= 1'b0;
  endtask

  task automatic chk_irq(input logic [3:0] e);
    idle(3);
    @(negedge clock);
    chk(32'(irq), 32'(e));
  endtask

  task automatic wait_starts(input int n);
    int t;
    t = n_starts + n;
    for (int k = 0; k < 3000 && n_starts < t; k++) @(posedge clock);
    idle(25);
  endtask

  task automatic pulse();
    @(posedge clock);
    rnd = xs(rnd);
    trig <= {rnd[2:0], 1'b1};
    @(posedge clock);
    trig <= {rnd[5:3], 1'b0};
  endtask

  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge clock)
    rd_seen <= bus.rd;
  always @(negedge clock)
    if (rd_seen === 1'b1)
    begin
      ent = exp_q.pop_front();
      chk(rdata & ent[63:32], ent[31:0]);
    end

  always @(posedge clock)
  begin
    if (req.start === 1'b1)
    begin
      n_starts++;
      chan_q.push_back(req.chan);
      delay <= rnd[3:0];
    end
    if (tick === 1'b1)
      n_ticks++;
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      conclude();
    end
  end

  initial
  begin
    bus = '0;
    trig = 4'h0;
    resetn = 1'b0;
    rnd = 32'd51527;
    idle(20);
    resetn <= 1'b1;
    rd(acs_pkg::OFF_PRI, 32'h3210, ALL);
    rd(ssa(3, acs_pkg::SUB_CTL), 32'h2, ALL);
    for (i = 0; i < 4; i++) rd(ssa(i, acs_pkg::SUB_FSTAT), 32'h100, ALL);
    rd(acs_pkg::OFF_SAC, 32'h0, ALL);
    rd(12'h0FC, 32'h0, ALL);
    rnd = xs(rnd);
    mux = rnd;
    wr(acs_pkg::OFF_EMUX, 32'h0);
    wr(ssa(0, acs_pkg::SUB_MUX), mux);
    wr(ssa(0, acs_pkg::SUB_CTL), 32'h0602_0480);
    s0 = n_starts;
    wr(acs_pkg::OFF_PSSI, 32'h1);
    idle(40);
    chk(32'(n_starts - s0), 32'h0);
    wr(acs_pkg::OFF_ACTSS, 32'h1);
    wr(acs_pkg::OFF_PSSI, 32'h1);
    wait_starts(5);
    chk(32'(n_starts - s0), 32'h5);
    rd(acs_pkg::OFF_RIS, 32'h1, ALL);
    rd(acs_pkg::OFF_ISC, 32'h0, ALL);
    chk_irq(4'h0);
    rd(ssa(0, acs_pkg::SUB_FSTAT), 32'h050, ALL);
    for (i = 0; i < 5; i++)
      rd(ssa(0, acs_pkg::SUB_FIFO),
         {22'h0, 1'b0, i == 1, mux[4*i +: 4], 4'h5}, ALL);
    rd(ssa(0, acs_pkg::SUB_FSTAT), 32'h155, ALL);
    rd(ssa(0, acs_pkg::SUB_FIFO), 32'h0, ALL);
    rd(acs_pkg::OFF_USTAT, 32'h1, ALL);
    wr(acs_pkg::OFF_USTAT, 32'h1);
    rd(acs_pkg::OFF_USTAT, 32'h0, ALL);
    wr(acs_pkg::OFF_IM, 32'h1);
    chk_irq(4'h1);
    rd(acs_pkg::OFF_ISC, 32'h1, ALL);
    wr(acs_pkg::OFF_ISC, 32'h1);
    rd(acs_pkg::OFF_RIS, 32'h0, ALL);
    chk_irq(4'h0);
    wr(ssa(1, acs_pkg::SUB_MUX), 32'h1);
    wr(ssa(1, acs_pkg::SUB_CTL), 32'h2);
    wr(ssa(2, acs_pkg::SUB_MUX), 32'h2);
    wr(ssa(2, acs_pkg::SUB_CTL), 32'h2);
    wr(acs_pkg::OFF_PRI, 32'h2013);
    rd(acs_pkg::OFF_PRI, 32'h2013, ALL);
    wr(acs_pkg::OFF_ACTSS, 32'h7);
    chan_q.delete();
    wr(acs_pkg::OFF_PSSI, 32'h6);
    wait_starts(2);
    chk(32'(chan_q.size()), 32'h2);
    chk(32'(chan_q[0]), 32'h2);
    chk(32'(chan_q[1]), 32'h1);
    wr(acs_pkg::OFF_SAC, 32'h2);
    rd(acs_pkg::OFF_SAC, 32'h2, ALL);
    s0 = n_starts;
    wr(acs_pkg::OFF_PSSI, 32'h2);
    wait_starts(4);
    chk(32'(n_starts - s0), 32'h4);
    for (i = 0; i < 2; i++) rd(ssa(1, acs_pkg::SUB_FIFO), 32'h015, ALL);
    rd(ssa(1, acs_pkg::SUB_FSTAT), 32'h100, 32'h1100);
    wr(acs_pkg::OFF_SAC, 32'h0);
    wr(ssa(3, acs_pkg::SUB_MUX), 32'h2);
    wr(ssa(3, acs_pkg::SUB_CTL), 32'h3);
    wr(acs_pkg::OFF_EMUX, 32'h1000);
    wr(acs_pkg::OFF_ACTSS, 32'hF);
    s0 = n_starts;
    wr(acs_pkg::OFF_PSSI, 32'h8);
    idle(40);
    chk(32'(n_starts - s0), 32'h0);
    pulse();
    wait_starts(1);
    rd(ssa(3, acs_pkg::SUB_FIFO), 32'h225, ALL);
    for (i = 0; i < 2; i++)
    begin
      pulse();
      wait_starts(1);
    end
    chk(32'(n_starts - s0), 32'h3);
    rd(acs_pkg::OFF_OSTAT, 32'h8, ALL);
    rd(ssa(3, acs_pkg::SUB_FSTAT), 32'h1000, 32'h1100);
    rd(ssa(3, acs_pkg::SUB_FIFO), 32'h225, ALL);
    wr(acs_pkg::OFF_EMUX, 32'hF000);
    s0 = n_starts;
    idle(80);
    chk(32'(n_starts - s0 >= 3), 32'h1);
    wr(acs_pkg::OFF_ACTSS, 32'h7);
    idle(40);
    wr(acs_pkg::OFF_TMLB, 32'h1);
    s0 = n_starts;
    wr(acs_pkg::OFF_PSSI, 32'h1);
    idle(100);
    chk(32'(n_starts - s0), 32'h0);
    rd(ssa(0, acs_pkg::SUB_FSTAT), 32'h0, 32'h100);
    t0 = n_ticks;
    idle(1200);
    chk(32'(n_ticks - t0 >= TWIN - 1 && n_ticks - t0 <= TWIN + 1), 32'h1);
    idle(4);
    conclude();
  end
endmodule
